// ### src/sbl_slave.sv
`timescale 1ns/10ps
`default_nettype none
module sbl_slave (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link
    sbl_if.slave_end bus,
    // peripheral register seen by local logic
    output logic [sbl_pkg::SBL_DATA_W-1:0] periph_out,
    output logic periph_loaded,
    input wire logic periph_in_valid,
    input wire logic [sbl_pkg::SBL_DATA_W-1:0] periph_in,
    // sign of last read word
    output logic last_neg
);
    import sbl_pkg::*;
    // ************************************************
    // arbiter
    // ************************************************
    logic [SBL_NUM_MASTERS-1:0] grant;
    logic [SBL_NUM_MASTERS-1:0] next_grant;
    logic bus_free;

    // lower index is the higher fixed priority
    function automatic logic [SBL_NUM_MASTERS-1:0] pick(
        input logic [SBL_NUM_MASTERS-1:0] req
    );
        logic [SBL_NUM_MASTERS-1:0] one;
        one = '0;
        for (int i = SBL_NUM_MASTERS - 1; i >= 0; i--) begin
            if (req[i]) begin
                one = '0;
                one[i] = 1'b1;
            end
        end
        return one;
    endfunction

    // the owner keeps its grant while it still asks: a master launching on its
    // grant must never meet a new owner chosen on the same edge
    assign bus_free = (bus.bus_busy == '0) && !bus.ssyn && !(|(grant & bus.bus_req));
    assign next_grant = bus_free ? pick(bus.bus_req) : grant;
    assign bus.bus_grant = grant;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            grant <= '0;
        end else begin
            grant <= next_grant;
        end
    end

    // ************************************************
    // address decode
    // ************************************************
    // memory has no request output at all: it only answers
    logic [15:0] mem [SBL_WORDS];
    sbl_slv_e state;
    logic [SBL_WORD_AW-1:0] widx;
    logic is_periph;
    logic owned;
    logic take;
    logic take_write;
    logic take_read;
    logic load_periph;
    logic [15:0] rword;
    logic [15:0] periph;

    assign widx = bus.addr[15:1];
    // the whole top page aliases the one peripheral register
    assign is_periph = (bus.addr & SBL_PERIPH_MASK) == SBL_PERIPH_BASE;
    // only a strobe from the granted, busy master counts
    assign owned = |(grant & bus.bus_busy);
    // a strobe is taken once, on the edge that leaves idle
    assign take = (state == SBL_S_IDLE) && bus.msyn && owned;
    assign take_write = take && bus.write;
    assign take_read = take && !bus.write;
    assign load_periph = take_write && is_periph;
    assign rword = is_periph ? periph : mem[widx];
    assign periph_out = periph;

    // byte lanes: an odd address selects the high byte
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] nw,
        input logic bo,
        input logic hi
    );
        if (!bo) begin
            return nw;
        end
        return hi ? {nw[7:0], old[7:0]} : {old[15:8], nw[7:0]};
    endfunction

    // ************************************************
    // storage and handshake state
    // ************************************************
    // no reset on the array: clearing 32k words would need a long sweep
    always_ff @(posedge core_clk) begin
        if (take_write && !is_periph) begin
            mem[widx] <= merge(mem[widx], bus.wdata, bus.byte_op, bus.addr[0]);
        end
    end

    // one transfer at a time: a new strobe is only seen back in idle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= SBL_S_IDLE;
        end else begin
            unique case (state)
                SBL_S_IDLE: begin
                    if (take) begin
                        state <= SBL_S_ACK;
                    end
                end
                SBL_S_ACK: begin
                    state <= SBL_S_WAIT;
                end
                SBL_S_WAIT: begin
                    if (!bus.msyn) begin
                        state <= SBL_S_IDLE;
                    end
                end
                default: begin
                    state <= SBL_S_IDLE;
                end
            endcase
        end
    end

    // ************************************************
    // answer
    // ************************************************
    // the answer stands until the strobe is withdrawn
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus.ssyn <= 1'b0;
        end else begin
            unique case (state)
                SBL_S_IDLE: begin
                    bus.ssyn <= 1'b0;
                end
                SBL_S_ACK: begin
                    bus.ssyn <= 1'b1;
                end
                SBL_S_WAIT: begin
                    if (!bus.msyn) begin
                        bus.ssyn <= 1'b0;
                    end
                end
                default: begin
                    bus.ssyn <= 1'b0;
                end
            endcase
        end
    end

    // read data is caught on the take edge and stands until the next read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus.rdata <= SBL_RESET_WORD;
        end else if (take_read) begin
            bus.rdata <= rword;
        end
    end

    // sign of the word handed out, kept until the next read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_neg <= 1'b0;
        end else if (take_read) begin
            last_neg <= sbl_is_neg(rword);
        end
    end

    // ************************************************
    // peripheral register
    // ************************************************
    // a bus load in the same cycle wins over the local load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            periph <= SBL_RESET_WORD;
        end else if (load_periph) begin
            periph <= merge(periph, bus.wdata, bus.byte_op, bus.addr[0]);
        end else if (periph_in_valid) begin
            periph <= periph_in;
        end
    end

    // one-cycle pulse per bus load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            periph_loaded <= 1'b0;
        end else begin
            periph_loaded <= load_periph;
        end
    end
endmodule
`default_nettype wire

// ### src/sbl_pkg.sv
// shared bus link package: widths, line counts, states
package sbl_pkg;
    localparam int SBL_ADDR_W = 16;
    localparam int SBL_DATA_W = 16;
    localparam int SBL_NUM_MASTERS = 2;
    localparam int SBL_BUS_LINES = 56;
    localparam int SBL_BYTES = 65536;
    localparam int SBL_WORDS = 32768;
    localparam int SBL_WORD_AW = 15;
    localparam int SBL_FIFO_DEPTH = 16;
    localparam logic [15:0] SBL_SIGN_MASK = 16'h8000;
    localparam logic [15:0] SBL_MAX_POS = 16'h7fff;
    localparam logic [15:0] SBL_MIN_NEG = 16'h8000;
    localparam logic [15:0] SBL_RESET_WORD = 16'h0000;
    // peripheral register window inside the address space
    localparam logic [15:0] SBL_PERIPH_BASE = 16'hff00;
    localparam logic [15:0] SBL_PERIPH_MASK = 16'hff00;

    typedef enum logic [3:0] {
        SBL_M_IDLE = 4'b0001,
        SBL_M_REQ = 4'b0010,
        SBL_M_XFER = 4'b0100,
        SBL_M_DONE = 4'b1000
    } sbl_mst_e;

    typedef enum logic [2:0] {
        SBL_S_IDLE = 3'b001,
        SBL_S_ACK = 3'b010,
        SBL_S_WAIT = 3'b100
    } sbl_slv_e;

    // bit 15 is the sign in two's complement words
    function automatic logic sbl_is_neg(input logic [15:0] w);
        return w[15];
    endfunction
endpackage

// ### src/sbl_if.sv
// shared bus link interface between the master end and the slave end
`timescale 1ns/10ps
`default_nettype none
interface sbl_if;
    import sbl_pkg::*;
    logic [SBL_NUM_MASTERS-1:0] bus_req;
    logic [SBL_NUM_MASTERS-1:0] bus_grant;
    logic [SBL_NUM_MASTERS-1:0] bus_busy;
    logic [SBL_ADDR_W-1:0] addr;
    logic write;
    logic byte_op;
    logic [SBL_DATA_W-1:0] wdata;
    logic [SBL_DATA_W-1:0] rdata;
    logic msyn;
    logic ssyn;
    modport master_end (
        output bus_req, bus_busy, addr, write, byte_op, wdata, msyn,
        input bus_grant, rdata, ssyn
    );
    modport slave_end (
        input bus_req, bus_busy, addr, write, byte_op, wdata, msyn,
        output bus_grant, rdata, ssyn
    );
endinterface
`default_nettype wire

// ### src/sbl_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/10ps
`default_nettype none
module sbl_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### src/sbl_master.sv
// bus master end: queues user requests and runs interlocked transfers
`timescale 1ns/10ps
`default_nettype none
module sbl_master (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fixed index of this master on the request lines
    input wire logic [0:0] master_id,
    // request stream: {write, byte_op, addr, wdata}
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [33:0] cmd_data,
    // answer
    output logic rsp_valid,
    output logic [sbl_pkg::SBL_DATA_W-1:0] rsp_data,
    // link
    sbl_if.master_end bus
);
    import sbl_pkg::*;
    sbl_mst_e state;
    logic q_valid;
    logic q_ready;
    logic [33:0] q_data;
    logic granted;

    sbl_fifo #(.WIDTH(34), .DEPTH(SBL_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_data),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    assign granted = bus.bus_grant[master_id];
    // drain only once the previous transfer has fully closed; the own request must
    // already stand so a grant left from the last transfer is never reused early
    assign q_ready = (state == SBL_M_IDLE) && q_valid && granted && bus.bus_req[master_id]
        && !bus.ssyn;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= SBL_M_IDLE;
            bus.bus_req <= '0;
            bus.bus_busy <= '0;
            bus.addr <= '0;
            bus.write <= 1'b0;
            bus.byte_op <= 1'b0;
            bus.wdata <= '0;
            bus.msyn <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state)
                SBL_M_IDLE: begin
                    bus.bus_req[master_id] <= q_valid;
                    bus.bus_busy[master_id] <= 1'b0;
                    // own the lines only while granted
                    if (q_ready && !bus.ssyn) begin
                        bus.bus_busy[master_id] <= 1'b1;
                        bus.write <= q_data[33];
                        bus.byte_op <= q_data[32];
                        bus.addr <= q_data[31:16];
                        bus.wdata <= q_data[15:0];
                        state <= SBL_M_REQ;
                    end
                end
                SBL_M_REQ: begin
                    bus.msyn <= 1'b1;
                    state <= SBL_M_XFER;
                end
                SBL_M_XFER: begin
                    if (bus.ssyn) begin
                        bus.msyn <= 1'b0;
                        rsp_data <= bus.rdata;
                        rsp_valid <= 1'b1;
                        state <= SBL_M_DONE;
                    end
                end
                SBL_M_DONE: begin
                    if (!bus.ssyn) begin
                        bus.bus_busy[master_id] <= 1'b0;
                        bus.bus_req[master_id] <= 1'b0;
                        state <= SBL_M_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### test/sbl_link_checker.sv
// checker: arbitration and interlocked handshake on the shared link
`timescale 1ns/10ps
`default_nettype none
module sbl_link_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // arbitration
    input wire logic [1:0] bus_req,
    input wire logic [1:0] bus_grant,
    input wire logic [1:0] bus_busy,
    // handshake
    input wire logic msyn,
    input wire logic ssyn
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_strobe;
        msyn && !ssyn;
    endsequence
    sequence s_answer;
        ##[1:4] ssyn;
    endsequence
    chk_one_owner: assert property ($onehot0(bus_grant))
        else $error("two grants at once");
    chk_strobe_owned: assert property (msyn |-> bus_grant != 2'b00 && bus_busy != 2'b00)
        else $error("strobe without ownership");
    chk_grant_prio: assert property ($rose(bus_grant[1]) |-> !$past(bus_req[0]))
        else $error("low priority master granted over high");
    chk_grant_asked: assert property ($rose(bus_grant[0]) |-> $past(bus_req[0]))
        else $error("grant without request");
    chk_no_stray_ack: assert property ($rose(ssyn) |-> msyn)
        else $error("answer without strobe");
    chk_slave_answers: assert property ($rose(msyn) |-> s_answer)
        else $error("strobe not answered in time");
    chk_strobe_held: assert property (s_strobe |=> msyn)
        else $error("strobe dropped before answer");
    chk_answer_held: assert property (ssyn && msyn |=> ssyn)
        else $error("answer dropped while strobe up");
    chk_answer_drops: assert property ($fell(msyn) |-> ##[0:3] !ssyn)
        else $error("answer not withdrawn");
endmodule
`default_nettype wire

// ### test/testbench.sv
// testbench: two masters and one slave joined over the shared link
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sbl_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] cmd_valid = 2'b00;
    logic [33:0] cmd_data [2] = '{'0, '0};
    wire [1:0] cmd_ready;
    wire [1:0] rsp_valid;
    wire [15:0] rsp_data [2];
    wire [15:0] periph_out;
    wire periph_loaded;
    wire last_neg;
    logic [15:0] periph_in = '0;
    logic periph_in_valid = 1'b0;
    logic seen_load = 1'b0;
    logic refused;
    int rsp_cnt = 0;
    int err_count = 0;
    int samples_checked = 0;
    int acc;
    int base;
    sbl_if bm0 ();
    sbl_if bm1 ();
    sbl_if bs ();
    // ****************************************
    // link merge: each master owns only its own bit
    // ****************************************
    assign bs.bus_req = {bm1.bus_req[1], bm0.bus_req[0]};
    assign bs.bus_busy = {bm1.bus_busy[1], bm0.bus_busy[0]};
    assign bs.addr = bs.bus_grant[1] ? bm1.addr : bm0.addr;
    assign bs.write = bs.bus_grant[1] ? bm1.write : bm0.write;
    assign bs.byte_op = bs.bus_grant[1] ? bm1.byte_op : bm0.byte_op;
    assign bs.wdata = bs.bus_grant[1] ? bm1.wdata : bm0.wdata;
    assign bs.msyn = bs.bus_grant[1] ? bm1.msyn : bm0.msyn;
    assign bm0.bus_grant = bs.bus_grant;
    assign bm1.bus_grant = bs.bus_grant;
    assign bm0.rdata = bs.rdata;
    assign bm1.rdata = bs.rdata;
    assign bm0.ssyn = bs.ssyn;
    assign bm1.ssyn = bs.ssyn;
    sbl_master u_sbl_master (.core_clk(core_clk), .rst(rst), .master_id(1'b0),
        .cmd_valid(cmd_valid[0]), .cmd_ready(cmd_ready[0]), .cmd_data(cmd_data[0]),
        .rsp_valid(rsp_valid[0]), .rsp_data(rsp_data[0]), .bus(bm0));
    sbl_master u_sbl_master_b (.core_clk(core_clk), .rst(rst), .master_id(1'b1),
        .cmd_valid(cmd_valid[1]), .cmd_ready(cmd_ready[1]), .cmd_data(cmd_data[1]),
        .rsp_valid(rsp_valid[1]), .rsp_data(rsp_data[1]), .bus(bm1));
    sbl_slave u_sbl_slave (.core_clk(core_clk), .rst(rst), .bus(bs),
        .periph_out(periph_out), .periph_loaded(periph_loaded),
        .periph_in_valid(periph_in_valid), .periph_in(periph_in), .last_neg(last_neg));
    sbl_link_checker u_sbl_link_checker (.core_clk(core_clk), .rst(rst),
        .bus_req(bs.bus_req), .bus_grant(bs.bus_grant), .bus_busy(bs.bus_busy),
        .msyn(bs.msyn), .ssyn(bs.ssyn));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) rsp_cnt <= rst ? 0 : rsp_cnt + int'(rsp_valid[0] === 1'b1);
    always @(posedge core_clk) if (periph_loaded === 1'b1) seen_load <= 1'b1;
    function automatic logic [33:0] cw(input logic w, input logic [15:0] a, input logic [15:0] v);
        return {w, 1'b0, a, v};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one whole transfer: hand over, then wait for the answer pulse
    task automatic xfer(input int m, input logic [33:0] c, output logic [15:0] d);
        int n;
        cmd_data[m] <= c;
        cmd_valid[m] <= 1'b1;
        @(negedge core_clk);
        while (cmd_ready[m] !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        cmd_valid[m] <= 1'b0;
        for (n = 0; n < 300 && rsp_valid[m] !== 1'b1; n++) @(negedge core_clk);
        if (n == 300) err_count++;
        d = rsp_data[m];
        @(posedge core_clk);
    endtask
    task automatic summarize();
        $display("errors %0d of %0d checks", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // the full run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        summarize();
    end
    initial begin
        logic [15:0] d;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        xfer(0, cw(1'b1, 16'h0010, SBL_MIN_NEG), d);
        xfer(0, cw(1'b1, 16'hfefe, 16'h1234), d);
        xfer(1, cw(1'b0, 16'h0010, 16'h0000), d);
        check(d, SBL_MIN_NEG);
        check({15'h0, last_neg}, 16'h0001);
        // byte load at the odd address touches only the high byte
        xfer(0, {1'b1, 1'b1, 16'h0011, 16'h0055}, d);
        xfer(1, cw(1'b0, 16'h0010, 16'h0000), d);
        check(d, 16'h5500);
        xfer(0, cw(1'b0, 16'hfefe, 16'h0000), d);
        check(d, 16'h1234);
        check({15'h0, last_neg}, 16'h0000);
        xfer(1, cw(1'b1, SBL_PERIPH_BASE, SBL_MAX_POS), d);
        check(periph_out, SBL_MAX_POS);
        check({15'h0, seen_load}, 16'h0001);
        periph_in <= 16'h00c3;
        periph_in_valid <= 1'b1;
        @(posedge core_clk);
        periph_in_valid <= 1'b0;
        xfer(0, cw(1'b0, 16'hff02, 16'h0000), d);
        check(d, 16'h00c3);
        // same-cycle requests from both masters
        cmd_data[0] <= cw(1'b1, 16'h0020, 16'h0aaa);
        cmd_data[1] <= cw(1'b1, 16'h0020, 16'h0bbb);
        cmd_valid <= 2'b11;
        @(posedge core_clk);
        cmd_valid <= 2'b00;
        repeat (40) begin
            @(negedge core_clk);
            if (rsp_valid != 2'b00) break;
        end
        check({14'h0, rsp_valid}, 16'h0001);
        // the second master's queued write must close before it reads back
        repeat (40) begin
            @(negedge core_clk);
            if (rsp_valid[1] === 1'b1) break;
        end
        check({15'h0, rsp_valid[1]}, 16'h0001);
        @(posedge core_clk);
        xfer(1, cw(1'b0, 16'h0020, 16'h0000), d);
        check(d, 16'h0bbb);
        // stream writes for 30 cycles, past the point where the queue refuses, then let it drain
        acc = 0;
        refused = 1'b0;
        base = rsp_cnt;
        for (int i = 0; i < 30; i++) begin
            cmd_data[0] <= cw(1'b1, 16'(2 * acc), 16'(acc));
            cmd_valid[0] <= 1'b1;
            @(negedge core_clk);
            if (cmd_ready[0] === 1'b1) acc++;
            else refused = 1'b1;
            @(posedge core_clk);
        end
        cmd_valid[0] <= 1'b0;
        for (int n = 0; n < 600 && rsp_cnt != base + acc; n++) @(posedge core_clk);
        check({15'h0, refused}, 16'h0001);
        check(16'(rsp_cnt - base), 16'(acc));
        xfer(1, cw(1'b0, 16'(2 * (acc - 1)), 16'h0000), d);
        check(d, 16'(acc - 1));
        summarize();
    end
endmodule
`default_nettype wire
